/* hw/aux_enc_pkg.sv */
// Constants, register map and carrier types for the auxiliary encoder block.
// Assumes an APB master at 100 MHz and pins already synchronous to the clock.
package aux_enc_pkg;
   //---------------------------------------------------------------
   // Register map
   //---------------------------------------------------------------
   localparam logic [7:0] OFS_SRC_SEL   = 8'h00;
   localparam logic [7:0] OFS_MODE0     = 8'h04;
   localparam logic [7:0] OFS_SCALE     = 8'h10;
   localparam logic [7:0] OFS_KIND0     = 8'h14;
   localparam logic [7:0] OFS_POS0      = 8'h20;
   localparam logic [7:0] OFS_STATUS    = 8'h30;
   localparam int         NUM_CH        = 3;
   localparam logic [1:0] SRC_NONE      = 2'h3;  // Two's complement of minus one
   localparam logic [1:0] SRC_PRIMARY   = 2'h0;
   localparam logic [1:0] SRC_FAST      = 2'h1;
   localparam logic [1:0] SRC_EXTRA     = 2'h2;
   localparam int         MODE_STEP_BIT = 2;
   localparam logic [2:0] KIND_HALL_LO  = 3'h4;
   localparam logic [2:0] KIND_HALL_HI  = 3'h5;
   localparam logic [2:0] KIND_WITH_HALL_LO = 3'h2;
   localparam logic [15:0] SCALE_UNITY  = 16'h0100;  // 8.8 fixed point, 1.0
   localparam int         SCALE_FRAC    = 8;
   // Output lag budget when not in pass-through
   localparam int         CLK_MHZ       = 100;
   localparam int         LAG_US        = 125;
   localparam int         LAG_CYCLES    = LAG_US * CLK_MHZ;
   localparam int         POS_W         = 32;

   typedef struct packed {
      logic a;
      logic b;
      logic z;
   } quad_s;

   typedef struct packed {
      logic step;
      logic up;
   } motion_s;
endpackage : aux_enc_pkg

/* hw/quad_decoder.sv */
// Quadrature / step-direction decoder for one channel.
// Assumes inputs already synchronous; emits one-cycle count events.
`timescale 1ns/1ps
`default_nettype none
module quad_decoder
   import aux_enc_pkg::*;
#(
   parameter bit HAS_INDEX = 1'b1
) (
   input  wire logic    clk,
   input  wire logic    rst,
   input  wire quad_s   pins,
   input  wire logic    step_mode,
   output motion_s      ev,
   output logic         index_ev
);
   quad_s prev_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= pins;
      end
   end

   always_comb begin
      ev       = '0;
      index_ev = 1'b0;
      if (step_mode) begin
         ev.step = pins.a & ~prev_reg.a;
         ev.up   = pins.b;
      end else begin
         // Gray step: A edge with A!=B or B edge with A==B counts up
         ev.step = (pins.a ^ prev_reg.a) | (pins.b ^ prev_reg.b);
         ev.up   = (pins.a ^ prev_reg.a) ? (pins.a != pins.b) : (pins.a == pins.b);
         // Index only in ABZ mode, and never on the fast-input channel
         index_ev = HAS_INDEX & pins.z & ~prev_reg.z;
      end
   end
endmodule : quad_decoder
`default_nettype wire

/* hw/quad_synth.sv */
// Quadrature output synthesiser: each step request moves the AB state one step, up or down.
// Assumes step requests no faster than one per two cycles is not needed.
`timescale 1ns/1ps
`default_nettype none
module quad_synth
   import aux_enc_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    rst,
   input  wire motion_s req,
   output logic [1:0]   ab
);
   logic [1:0] phase_reg;

   // Gray sequence 00,01,11,10 gives 50% duty and 90 degree spacing
   always_ff @(posedge clk) begin
      if (rst) begin
         phase_reg <= 2'h0;
      end else if (req.step) begin
         phase_reg <= req.up ? phase_reg + 2'h1 : phase_reg - 2'h1;
      end
   end

   assign ab = {phase_reg[1], phase_reg[1] ^ phase_reg[0]};
endmodule : quad_synth
`default_nettype wire

/* hw/aux_encoder_io_emulation.sv */
// Top of the auxiliary encoder block: three input channels, emulated output.
// Assumes an APB master on I_CLOCK and synchronous pin inputs.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module aux_encoder_io_emulation
   import aux_enc_pkg::*;
#(
   parameter int LAG_LIMIT = LAG_CYCLES
) (
   input  wire logic        I_CLOCK,
   input  wire logic        I_RESET,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire quad_s       I_PRIMARY_PINS,
   input  wire logic        I_FAST_INPUT_ONE,
   input  wire logic        I_FAST_INPUT_TWO,
   input  wire quad_s       I_AUX_PINS,
   input  wire quad_s       I_PRIMARY_SPARE_PINS,
   output logic [1:0]       O_AUX_AB,
   output logic [1:0]       O_AUX_AB_OE,
   output logic             O_EXTRA_ON_PRIMARY
);
   // Refused at elaboration: the lag watch needs a positive budget
   if (LAG_LIMIT < 1) begin : g_lag_check
      $error("LAG_LIMIT must be positive");
   end

   //---------------------------------------------------------------
   // Registers
   //---------------------------------------------------------------
   logic [1:0]      src_sel_reg;
   logic [2:0]      mode_reg [NUM_CH];
   logic [2:0]      kind_reg [NUM_CH];
   logic [15:0]     scale_reg;
   logic [POS_W-1:0] pos_reg [NUM_CH];
   logic [NUM_CH-1:0] index_seen_reg;
   logic [15:0]     acc_reg;
   logic [31:0]     lag_reg;
   logic            lag_err_reg;

   logic output_mode;
   assign output_mode = (src_sel_reg != SRC_NONE);

   function automatic logic step_sel(input logic [2:0] m);
      step_sel = m[MODE_STEP_BIT];
   endfunction : step_sel

   //---------------------------------------------------------------
   // Channel decode
   //---------------------------------------------------------------
   quad_s   ch_pins [NUM_CH];
   motion_s ch_ev   [NUM_CH];
   logic    ch_idx  [NUM_CH];

   assign ch_pins[0] = I_PRIMARY_PINS;
   assign ch_pins[1] = '{a: I_FAST_INPUT_ONE, b: I_FAST_INPUT_TWO, z: 1'b0};
   // Extra channel moves to the spare primary pins in output mode
   assign ch_pins[2] = output_mode ? I_PRIMARY_SPARE_PINS : I_AUX_PINS;

   // Halls-only kinds carry no quadrature on channel 0
   logic ch0_quad;
   assign ch0_quad = !(kind_reg[0] == KIND_HALL_LO || kind_reg[0] == KIND_HALL_HI);

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         quad_decoder #(.HAS_INDEX(g != 1)) u_dec (
            .clk      (I_CLOCK),
            .rst      (I_RESET),
            .pins     (ch_pins[g]),
            .step_mode(step_sel(mode_reg[g])),
            .ev       (ch_ev[g]),
            .index_ev (ch_idx[g])
         );
      end
   endgenerate

   logic ch_move [NUM_CH];
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         ch_move[i] = ch_ev[i].step & ((i != 0) | ch0_quad);
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RESET) begin
         for (int i = 0; i < NUM_CH; i++) pos_reg[i] <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (ch_move[i]) pos_reg[i] <= ch_ev[i].up ? pos_reg[i] + 1'b1 : pos_reg[i] - 1'b1;
         end
      end
   end

   // Index latch; hardware set wins over software clear
   logic [NUM_CH-1:0] idx_clr;
   always_ff @(posedge I_CLOCK) begin
      if (I_RESET) begin
         index_seen_reg <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (ch_idx[i]) index_seen_reg[i] <= 1'b1;
            else if (idx_clr[i]) index_seen_reg[i] <= 1'b0;
         end
      end
   end

   //---------------------------------------------------------------
   // Emulated output
   //---------------------------------------------------------------
   motion_s src_ev;
   always_comb begin
      case (src_sel_reg)
         SRC_PRIMARY: src_ev = '{step: ch_move[0], up: ch_ev[0].up};
         SRC_FAST:    src_ev = '{step: ch_move[1], up: ch_ev[1].up};
         SRC_EXTRA:   src_ev = '{step: ch_move[2], up: ch_ev[2].up};
         default:     src_ev = '0;
      endcase
   end

   // Scale by accumulation; unity bypasses it so edges pass at once
   logic        unity;
   logic [16:0] acc_sum;
   motion_s     out_req;
   assign unity   = (scale_reg == SCALE_UNITY);
   assign acc_sum = {1'b0, acc_reg} + (src_ev.step ? {1'b0, scale_reg} : 17'h0);
   always_comb begin
      out_req.up   = src_ev.up;
      out_req.step = unity ? src_ev.step : (acc_sum >= {1'b0, SCALE_UNITY});
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RESET || unity || !output_mode) begin
         acc_reg <= '0;
      end else if (out_req.step) begin
         acc_reg <= 16'(acc_sum - {1'b0, SCALE_UNITY});
      end else begin
         acc_reg <= acc_sum[15:0];
      end
   end

   // Watch the residue age: flag if it waits longer than the lag budget
   always_ff @(posedge I_CLOCK) begin
      if (I_RESET || unity || acc_reg == '0 || out_req.step) begin
         lag_reg <= '0;
      end else if (lag_reg < 32'(LAG_LIMIT)) begin
         lag_reg <= lag_reg + 32'h1;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (I_RESET) lag_err_reg <= 1'b0;
      else if (lag_reg == 32'(LAG_LIMIT)) lag_err_reg <= 1'b1;
      else if (idx_clr[0]) lag_err_reg <= 1'b0;
   end

   logic [1:0] synth_ab;
   quad_synth u_synth (
      .clk (I_CLOCK),
      .rst (I_RESET || !output_mode),
      .req (out_req),
      .ab  (synth_ab)
   );

   always_ff @(posedge I_CLOCK) begin
      if (I_RESET) begin
         O_AUX_AB           <= 2'h0;
         O_AUX_AB_OE        <= 2'h0;
         O_EXTRA_ON_PRIMARY <= 1'b0;
      end else begin
         O_AUX_AB           <= output_mode ? synth_ab : 2'h0;
         O_AUX_AB_OE        <= {2{output_mode}};
         O_EXTRA_ON_PRIMARY <= output_mode;
      end
   end

   //---------------------------------------------------------------
   // APB slave
   //---------------------------------------------------------------
   logic wr;
   logic rd;
   logic [7:0] rel;
   logic [1:0] idx;
   assign wr  = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
   assign rd  = I_PSEL & ~I_PENABLE & ~I_PWRITE;
   assign idx = I_PADDR[3:2];
   assign idx_clr = (wr && I_PADDR == OFS_STATUS) ? I_PWDATA[NUM_CH-1:0] : '0;

   function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
      in_bank = (a >= base) && (a < base + 8'(4 * NUM_CH)) && (a[1:0] == 2'h0);
   endfunction : in_bank

   always_ff @(posedge I_CLOCK) begin
      if (I_RESET) begin
         src_sel_reg <= SRC_NONE;
         scale_reg   <= SCALE_UNITY;
         for (int i = 0; i < NUM_CH; i++) begin
            mode_reg[i] <= 3'h0;
            kind_reg[i] <= 3'h0;
         end
      end else if (wr) begin
         if (I_PADDR == OFS_SRC_SEL) src_sel_reg <= I_PWDATA[1:0];
         if (I_PADDR == OFS_SCALE && I_PWDATA[15:0] != 16'h0) scale_reg <= I_PWDATA[15:0];
         if (in_bank(I_PADDR, OFS_MODE0)) mode_reg[idx - OFS_MODE0[3:2]] <= I_PWDATA[2:0];
         if (in_bank(I_PADDR, OFS_KIND0)) kind_reg[2'(idx - OFS_KIND0[3:2])] <= I_PWDATA[2:0];
      end
   end

   // Zero-wait: ready high in every access phase
   always_ff @(posedge I_CLOCK) begin
      if (I_RESET) begin
         O_PRDATA  <= 32'h0;
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY  <= I_PSEL & ~I_PENABLE;
         O_PSLVERR <= 1'b0;
         if (rd) begin
            O_PRDATA <= 32'h0;
            if (I_PADDR == OFS_SRC_SEL) O_PRDATA <= {{30{src_sel_reg[1] & src_sel_reg[0]}}, src_sel_reg};
            else if (I_PADDR == OFS_SCALE) O_PRDATA <= {16'h0, scale_reg};
            else if (I_PADDR == OFS_STATUS) O_PRDATA <= {27'h0, lag_err_reg, ch0_quad, index_seen_reg};
            else if (in_bank(I_PADDR, OFS_MODE0)) O_PRDATA <= {29'h0, mode_reg[idx - OFS_MODE0[3:2]]};
            else if (in_bank(I_PADDR, OFS_KIND0)) O_PRDATA <= {29'h0, kind_reg[2'(idx - OFS_KIND0[3:2])]};
            else if (in_bank(I_PADDR, OFS_POS0)) O_PRDATA <= pos_reg[idx];
            else O_PSLVERR <= 1'b1;
         end else if (I_PSEL & ~I_PENABLE & I_PWRITE) begin
            O_PSLVERR <= !(I_PADDR == OFS_SRC_SEL || I_PADDR == OFS_SCALE || I_PADDR == OFS_STATUS
                           || in_bank(I_PADDR, OFS_MODE0) || in_bank(I_PADDR, OFS_KIND0));
         end
      end
   end
endmodule : aux_encoder_io_emulation
`default_nettype wire

/* verification/enc_model.sv */
// Far-side feedback source: quadrature encoder or step and direction pulser.
// Assumes the bench spaces go pulses at least one quadrature gap apart.
`timescale 1ns/1ps
`default_nettype none
module enc_model
   import aux_enc_pkg::*;
(
   input  wire logic clk,
   input  wire logic go,
   input  wire logic up,
   input  wire logic step,
   input  wire logic z_in,
   output quad_s     pins
);
   logic [1:0] ph_reg = 2'h0;
   logic [3:0] hi_reg = 4'h0;
   always_ff @(posedge clk) begin
      if (go && !step) ph_reg <= up ? ph_reg + 2'h1 : ph_reg - 2'h1;
      hi_reg <= (go && step) ? 4'h6 : (hi_reg != 4'h0 ? hi_reg - 4'h1 : 4'h0);
   end
   // Gray coded so A leads B when moving up
   assign pins = step ? {hi_reg != 4'h0, up, z_in} : {^ph_reg, ph_reg[1], z_in};
endmodule : enc_model
`default_nettype wire

/* verification/aux_encoder_io_emulation_checker.sv */
// Port checker for the auxiliary encoder block.
// Assumes binding to the top; source select is tracked from APB writes.
`timescale 1ns/1ps
`default_nettype none
module aux_enc_checker
   import aux_enc_pkg::*;
#(
   parameter int LAG_LIMIT = LAG_CYCLES
) (
   input wire logic        I_CLOCK,
   input wire logic        I_RESET,
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic        I_PWRITE,
   input wire logic [7:0]  I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic        O_PREADY,
   input wire logic        O_PSLVERR,
   input wire logic [1:0]  O_AUX_AB,
   input wire logic [1:0]  O_AUX_AB_OE,
   input wire logic        O_EXTRA_ON_PRIMARY
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RESET);
   logic [1:0] src_reg;
   logic       mapped;
   always_ff @(posedge I_CLOCK) begin
      if (I_RESET) src_reg <= SRC_NONE;
      else if (I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && I_PADDR == OFS_SRC_SEL) src_reg <= I_PWDATA[1:0];
   end
   // Positions are read-only, so a write to them is refused
   assign mapped = (I_PADDR[1:0] == 2'h0)
                   && ((I_PADDR <= 8'h28 && !(I_PWRITE && I_PADDR >= OFS_POS0)) || I_PADDR == OFS_STATUS);
   sequence setup_s;
      I_PSEL && !I_PENABLE;
   endsequence
   sequence idle_src_s;
      (src_reg == SRC_NONE) [*3];
   endsequence
   sequence out_src_s;
      (src_reg != SRC_NONE) [*3];
   endsequence
   a_input_no_drive: assert property (idle_src_s |-> O_AUX_AB_OE == 2'h0 && O_AUX_AB == 2'h0)
      else $error("aux pins driven while input");
   a_output_drives: assert property (out_src_s |-> O_AUX_AB_OE == 2'h3 && O_EXTRA_ON_PRIMARY)
      else $error("output mode not driving");
   a_reset_input: assert property ($fell(I_RESET) |-> (O_AUX_AB_OE == 2'h0) [*2])
      else $error("output enabled after reset");
   a_gray_step: assert property (O_AUX_AB_OE == 2'h3 && $past(O_AUX_AB_OE) == 2'h3
      && O_AUX_AB != $past(O_AUX_AB) |-> $onehot(O_AUX_AB ^ $past(O_AUX_AB)))
      else $error("both output phases moved at once");
   a_extra_tracks: assert property (O_EXTRA_ON_PRIMARY == (O_AUX_AB_OE == 2'h3))
      else $error("extra routing disagrees with output mode");
   a_ready_pulse: assert property (setup_s |=> O_PREADY ##1 !O_PREADY)
      else $error("ready not one cycle after setup");
   a_ready_idle: assert property (!I_PSEL |=> !O_PREADY)
      else $error("ready without select");
   a_slverr_map: assert property (O_PREADY |-> O_PSLVERR == !mapped)
      else $error("error flag wrong for address");
endmodule : aux_enc_checker
bind aux_encoder_io_emulation aux_enc_checker #(.LAG_LIMIT(LAG_LIMIT)) chk_u (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET),
   .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
   .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_AUX_AB(O_AUX_AB), .O_AUX_AB_OE(O_AUX_AB_OE),
   .O_EXTRA_ON_PRIMARY(O_EXTRA_ON_PRIMARY));
`default_nettype wire

/* verification/tb_aux_encoder_io_emulation.sv */
// Self-checking bench: four feedback sources, APB master, edge counter.
// Assumes the checker is bound; lag limit shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_aux_encoder_io_emulation;
   import aux_enc_pkg::*;
   localparam int GAP = 13;  // Keeps each phase at or below 2 MHz
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic        prdy, perr, xon, ev, u;
   logic [1:0]  ab, oe, ab_q;
   logic [3:0]  go = 4'h0, up = 4'h0, st = 4'h0, zz = 4'h0;
   quad_s       mp [4];
   quad_s       aux_w;
   logic [31:0] pos [3];
   int          n_errors = 0, checks = 0, seed = 95, n_out = 0, n, k;
   int          srcm [4] = '{0, 1, 3, 0};
   // Aux wire: design wins where it enables its driver
   assign aux_w = {oe[1] ? ab[1] : mp[2].a, oe[0] ? ab[0] : mp[2].b, mp[2].z};
   for (genvar g = 0; g < 4; g++) begin : enc_g
      enc_model m_u (.clk(clk), .go(go[g]), .up(up[g]), .step(st[g]), .z_in(zz[g]), .pins(mp[g]));
   end
   aux_encoder_io_emulation #(.LAG_LIMIT(20)) dut_u (.I_CLOCK(clk), .I_RESET(rst), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(prdy), .O_PSLVERR(perr), .I_PRIMARY_PINS(mp[0]), .I_FAST_INPUT_ONE(mp[1].a),
      .I_FAST_INPUT_TWO(mp[1].b), .I_AUX_PINS(aux_w), .I_PRIMARY_SPARE_PINS(mp[3]), .O_AUX_AB(ab),
      .O_AUX_AB_OE(oe), .O_EXTRA_ON_PRIMARY(xon));
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      ab_q <= ab;
      if (oe == 2'h3 && ab != ab_q) n_out <= n_out + 1;
   end
   //---------------------------------------------------------------
   // Tasks
   //---------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk) pen <= 1'b1;
      do begin @(posedge clk); t++; end while (prdy !== 1'b1 && t < 40);
      if (prdy !== 1'b1) begin n_errors++; end_of_test(); end
      rdv = prdata;
      ev = perr;
      psel <= 1'b0; pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rdv & m, e);
   endtask : rd
   task automatic mv(input int i, input logic dir, input int cnt);
      repeat (cnt) begin
         go[i] <= 1'b1; up[i] <= dir;
         @(posedge clk) go[i] <= 1'b0;
         // A step is a whole A period, so it needs four quadrature gaps
         repeat (st[i] ? 4 * GAP : GAP) @(posedge clk);
      end
   endtask : mv
   task automatic zp;
      zz[2] <= 1'b1; repeat (4) @(posedge clk); zz[2] <= 1'b0; repeat (4) @(posedge clk);
   endtask : zp
   function automatic logic [31:0] moved(input logic [31:0] p, input logic dir, input int c);
      return dir ? p + 32'(c) : p - 32'(c);
   endfunction : moved
   //---------------------------------------------------------------
   // Main sequence
   //---------------------------------------------------------------
   initial begin
      pos = '{default: 32'h0};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(OFS_SRC_SEL, 32'hFFFFFFFF, '1, "src");
      rd(OFS_SCALE, 32'h100, '1, "scale");
      chk("oe", oe, 2'h0);
      chk("xon", xon, 1'b0);
      $display("test reset done");
      for (int r = 0; r < 6; r++) begin
         k = 1 + r % 2;
         n = 1 + ($random(seed) & 7);
         u = 1'($random(seed) & 1);
         mv(k, u, n);
         pos[k] = moved(pos[k], u, n);
         rd(OFS_POS0 + 8'(4 * k), pos[k], '1, "pos");
      end
      for (int kd = 0; kd < 6; kd++) begin
         apb(1'b1, OFS_KIND0, 32'(kd));
         mv(0, 1'b1, 2);
         if (kd < 4) pos[0] = moved(pos[0], 1'b1, 2);
         rd(OFS_POS0, pos[0], '1, "kind");
      end
      apb(1'b1, OFS_KIND0, 32'h0);
      $display("test decode done");
      apb(1'b1, OFS_MODE0 + 8'h8, 32'h4 | (32'($random(seed)) & 32'hF8));
      st[2] <= 1'b1;
      for (int r = 0; r < 2; r++) begin
         n = 1 + ($random(seed) & 7);
         mv(2, 1'(r), n);
         pos[2] = moved(pos[2], 1'(r), n);
      end
      zp();
      rd(OFS_POS0 + 8'h8, pos[2], '1, "step");
      rd(OFS_STATUS, 32'h0, 32'h7, "idx off");
      apb(1'b1, OFS_MODE0 + 8'h8, 32'h0);
      st[2] <= 1'b0;
      zp();
      rd(OFS_STATUS, 32'h4, 32'h7, "idx seen");
      apb(1'b1, OFS_STATUS, 32'h7);
      rd(OFS_STATUS, 32'h0, 32'h7, "idx clear");
      $display("test step done");
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, OFS_SRC_SEL, 32'(s % 3));
         if (s == 3) apb(1'b1, OFS_SCALE, 32'h200);
         repeat (30) @(posedge clk);
         chk("oe", oe, 2'h3);
         chk("xon", xon, 1'b1);
         k = n_out;
         n = 1 + ($random(seed) & 7);
         mv(srcm[s], 1'b1, n);
         repeat (30) @(posedge clk);
         chk("edges", n_out - k, s == 3 ? 2 * n : n);
      end
      rd(OFS_STATUS, 32'h8, 32'h18, "lag");
      apb(1'b1, OFS_SCALE, 32'h0);
      rd(OFS_SCALE, 32'h200, '1, "scale zero");
      apb(1'b0, 8'h3C, 32'h0);
      chk("slverr", ev, 1'b1);
      apb(1'b1, OFS_SRC_SEL, 32'hFFFFFFFF);
      repeat (4) @(posedge clk);
      chk("oe", oe, 2'h0);
      $display("test output done");
      end_of_test();
   end
endmodule : tb_aux_encoder_io_emulation
`default_nettype wire
